// ---- common/seac_map.svh ----
// What this block does
// RULE1: the 4 Kbit array is seen as 512 bytes or 256 sixteen-bit words, picked by the width select.
// RULE2: a read copies its start address into the pointer and then shifts that location out.
// RULE3: after each location the pointer steps and the stream goes on while select stays high.
// RULE4: the pointer wraps from the top address to zero, so a burst runs 8 to 4096 bits or forever.
// RULE5: programming is timed inside, whether the serial clock keeps running or stops.
// RULE6: a single write needs no erase first; the device does whatever erase it needs.
// RULE7: a single write programs one location only, 8 bits by byte or 16 bits by word.
// RULE8: once programming has begun, select high shows busy (low) or ready (high) on data out.
// RULE9: the host holds select low at least 250 ns between instructions.
// RULE10: the host keeps each serial clock period at 1 us or longer.
// RULE11: after select rises, data in is sampled on clock rises, zeros skipped, first one is start.
// RULE12: an instruction is a 2-bit opcode then the address: 10 read, 01 write, 11 erase, 00 group.
// RULE13: width select high gives words with 8 address bits, low gives bytes with 9 address bits.
// RULE14: a read sends one zero bit before the first location, MSB first, and none between locations.
// RULE15: while programming runs, data in is ignored and no instruction is decoded.
// RULE16: select low stops driving data out and drops any partial instruction.
`ifndef SEAC_MAP_SVH
`define SEAC_MAP_SVH
`define SEAC_OP_MISC      2'h0
`define SEAC_OP_WRITE     2'h1
`define SEAC_OP_READ      2'h2
`define SEAC_OP_ERASE     2'h3
`define SEAC_SUB_EWDS     2'h0
`define SEAC_SUB_WRAL     2'h1
`define SEAC_SUB_ERAL     2'h2
`define SEAC_SUB_EWEN     2'h3
`define SEAC_WORD_ABITS   5'h0A
`define SEAC_BYTE_ABITS   5'h0B
`define SEAC_WORD_DBITS   5'h10
`define SEAC_BYTE_DBITS   5'h08
`define SEAC_ERASED       16'hFFFF
`define SEAC_LAST_WORD    8'hFF
`define SEAC_BUF_DEPTH    2'h2
`define SEAC_TIMER_W      22
`define SEAC_PROG_TIME_NS 10000000
`define SEAC_CLK_PERIOD_NS 5
`endif

// ---- common/seac_pkg.sv ----
`default_nettype none
`include "seac_map.svh"
package seac_pkg;
  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_CMD   = 7'h02,
    ST_DATA  = 7'h04,
    ST_READ  = 7'h08,
    ST_DONE  = 7'h10,
    ST_SWEEP = 7'h20,
    ST_BUSY  = 7'h40
  } seac_state_t;

  typedef struct packed {
    seac_state_t              state;
    logic                     sclk_q;
    logic                     org_word;
    logic [4:0]               cnt;
    logic [10:0]              cmd;
    logic [1:0]               op;
    logic [8:0]               addr;
    logic                     all;
    logic                     prog;
    logic                     wen;
    logic                     status;
    logic [15:0]              data;
    logic [`SEAC_TIMER_W-1:0] timer;
    logic [7:0]               sweep;
    logic [8:0]               ptr;
    logic [15:0]              buf0;
    logic [15:0]              buf1;
    logic [1:0]               bcnt;
    logic                     pend;
    logic                     pf_lo;
    logic [15:0]              osh;
    logic [4:0]               obits;
    logic                     sdo;
    logic                     oe;
  } seac_regs_t;

  localparam seac_regs_t SEAC_REGS_RST = '{state: ST_IDLE, default: '0};
endpackage
`default_nettype wire

// ---- common/seac_mem_if.sv ----
`default_nettype none
interface seac_mem_if;
  logic [7:0]  addr;
  logic        rd_en;
  logic        wr_en;
  logic [1:0]  wr_be;
  logic [15:0] wr_data;
  logic [15:0] rd_data;
  modport ctrl (output addr, output rd_en, output wr_en, output wr_be, output wr_data,
                input rd_data);
  modport mem (input addr, input rd_en, input wr_en, input wr_be, input wr_data,
               output rd_data);
endinterface
`default_nettype wire

// ---- rtl/seac_mem.sv ----
`default_nettype none
module seac_mem (
  input wire logic clk_in,
  seac_mem_if.mem  port
);
  // no reset on the array: contents are nonvolatile by intent
  logic [15:0] cells [0:255];

  always_ff @(posedge clk_in) begin
    if (port.wr_en && port.wr_be[1]) begin
      cells[port.addr][15:8] <= port.wr_data[15:8];
    end
    if (port.wr_en && port.wr_be[0]) begin
      cells[port.addr][7:0] <= port.wr_data[7:0];
    end
    if (port.rd_en) begin
      port.rd_data <= cells[port.addr];
    end
  end
endmodule
`default_nettype wire

// ---- rtl/seac_core.sv ----
`include "seac_map.svh"
`default_nettype none
module seac_core #(
  parameter int unsigned PROG_CYCLES = `SEAC_PROG_TIME_NS / `SEAC_CLK_PERIOD_NS
) (
  input  wire logic REF_CLK_IN,
  input  wire logic RESET_N_IN,
  input  wire logic SEL_IN,
  input  wire logic SCLK_IN,
  input  wire logic SDI_IN,
  input  wire logic WIDTH_SEL_IN,
  output logic      SDO_OUT,
  output logic      SDO_OE_OUT
);
  seac_pkg::seac_regs_t st_reg;
  seac_pkg::seac_regs_t st_next;
  logic                 sclk_rise;
  logic [10:0]          cmd_next;
  logic [1:0]           op_dec;
  logic [8:0]           addr_dec;
  logic [15:0]          push_word;
  logic                 push;
  logic                 pop;

  seac_mem_if mem_if ();

  seac_mem u_mem (
    .clk_in (REF_CLK_IN),
    .port   (mem_if.mem)
  );

  function automatic logic [7:0] word_addr(input logic [8:0] a, input logic w);
    return w ? a[7:0] : a[8:1];
  endfunction

  function automatic logic [4:0] data_bits(input logic w);
    return w ? `SEAC_WORD_DBITS : `SEAC_BYTE_DBITS;
  endfunction

  always_comb begin
    st_next        = st_reg;
    st_next.sclk_q = SCLK_IN;
    st_next.pend   = 1'b0;
    sclk_rise      = SCLK_IN && !st_reg.sclk_q;
    cmd_next       = {st_reg.cmd[9:0], SDI_IN};
    op_dec         = st_reg.org_word ? cmd_next[9:8] : cmd_next[10:9]; // RULE12
    addr_dec       = st_reg.org_word ? {1'b0, cmd_next[7:0]} : cmd_next[8:0]; // RULE13
    // bytes sit in the upper lane at even addresses, lower lane at odd ones
    push_word      = st_reg.org_word ? mem_if.rd_data
                   : {st_reg.pf_lo ? mem_if.rd_data[7:0] : mem_if.rd_data[15:8], 8'h00}; // RULE1
    pop            = 1'b0;
    push           = 1'b0;
    mem_if.rd_en   = 1'b0;
    mem_if.wr_en   = 1'b0;
    mem_if.addr    = 8'h00;
    mem_if.wr_be   = 2'h0;
    mem_if.wr_data = st_reg.org_word ? st_reg.data : {st_reg.data[7:0], st_reg.data[7:0]};

    if (!SEL_IN && !(st_reg.state inside {seac_pkg::ST_SWEEP, seac_pkg::ST_BUSY})) begin
      // select low ends everything except a running program cycle
      st_next.state = seac_pkg::ST_IDLE; // RULE16
      st_next.prog  = 1'b0;
      st_next.bcnt  = 2'h0;
      if (st_reg.state == seac_pkg::ST_DONE && st_reg.prog && st_reg.wen) begin
        st_next.status = 1'b1;
        st_next.sweep  = 8'h00;
        if (st_reg.all) begin
          st_next.state = seac_pkg::ST_SWEEP;
        end else begin
          // overwrite in place: the old content never needs a separate erase
          mem_if.wr_en  = 1'b1; // RULE6
          mem_if.addr   = word_addr(st_reg.addr, st_reg.org_word);
          mem_if.wr_be  = st_reg.org_word ? 2'h3 : (st_reg.addr[0] ? 2'h1 : 2'h2); // RULE7
          st_next.state = seac_pkg::ST_BUSY;
          st_next.timer = `SEAC_TIMER_W'(PROG_CYCLES - 1); // RULE5
        end
      end
    end else begin
      unique case (st_reg.state)
        seac_pkg::ST_IDLE: begin
          if (SEL_IN && sclk_rise && SDI_IN) begin // RULE11
            st_next.state    = seac_pkg::ST_CMD;
            st_next.cnt      = 5'h00;
            st_next.cmd      = 11'h000;
            st_next.org_word = WIDTH_SEL_IN; // RULE13
            st_next.status   = 1'b0;
          end
        end
        seac_pkg::ST_CMD: begin
          if (sclk_rise) begin
            st_next.cmd = cmd_next;
            st_next.cnt = st_reg.cnt + 5'h01;
            if (st_reg.cnt + 5'h01 ==
                (st_reg.org_word ? `SEAC_WORD_ABITS : `SEAC_BYTE_ABITS)) begin
              st_next.op    = op_dec;
              st_next.addr  = addr_dec;
              st_next.all   = 1'b0;
              st_next.cnt   = 5'h00;
              st_next.data  = `SEAC_ERASED;
              st_next.state = seac_pkg::ST_DONE;
              unique case (op_dec) // RULE12
                `SEAC_OP_READ: begin
                  st_next.state = seac_pkg::ST_READ;
                  st_next.ptr   = addr_dec; // RULE2
                  st_next.sdo   = 1'b0; // RULE14
                  st_next.obits = 5'h00;
                  st_next.bcnt  = 2'h0;
                end
                `SEAC_OP_WRITE: begin
                  st_next.state = seac_pkg::ST_DATA;
                end
                `SEAC_OP_ERASE: begin
                  st_next.prog = 1'b1;
                end
                `SEAC_OP_MISC: begin
                  unique case (st_reg.org_word ? addr_dec[7:6] : addr_dec[8:7])
                    `SEAC_SUB_EWEN: begin
                      st_next.wen = 1'b1;
                    end
                    `SEAC_SUB_EWDS: begin
                      st_next.wen = 1'b0;
                    end
                    `SEAC_SUB_ERAL: begin
                      st_next.all  = 1'b1;
                      st_next.prog = 1'b1;
                    end
                    `SEAC_SUB_WRAL: begin
                      st_next.all   = 1'b1;
                      st_next.state = seac_pkg::ST_DATA;
                    end
                  endcase
                end
              endcase
            end
          end
        end
        seac_pkg::ST_DATA: begin
          if (sclk_rise) begin
            st_next.data = {st_reg.data[14:0], SDI_IN};
            st_next.cnt  = st_reg.cnt + 5'h01;
            if (st_reg.cnt + 5'h01 == data_bits(st_reg.org_word)) begin // RULE7
              st_next.state = seac_pkg::ST_DONE;
              st_next.prog  = 1'b1;
            end
          end
        end
        seac_pkg::ST_DONE: begin
          st_next.cnt = 5'h00;
        end
        seac_pkg::ST_READ: begin
          // prefetch fills the two-entry buffer; a clock period of many cycles hides latency
          if (!st_reg.pend && st_reg.bcnt < `SEAC_BUF_DEPTH) begin // RULE10
            mem_if.rd_en  = 1'b1;
            mem_if.addr   = word_addr(st_reg.ptr, st_reg.org_word);
            st_next.pend  = 1'b1;
            st_next.pf_lo = st_reg.ptr[0];
            st_next.ptr   = st_reg.org_word ? {1'b0, st_reg.ptr[7:0] + 8'h01}
                          : st_reg.ptr + 9'h001; // RULE3 RULE4
          end
          if (sclk_rise) begin
            if (st_reg.obits != 5'h00) begin
              st_next.sdo   = st_reg.osh[15];
              st_next.osh   = {st_reg.osh[14:0], 1'b0};
              st_next.obits = st_reg.obits - 5'h01;
            end else if (st_reg.bcnt != 2'h0) begin
              // next location follows straight on, no zero bit in between
              pop           = 1'b1; // RULE3 RULE14
              st_next.sdo   = st_reg.buf0[15];
              st_next.osh   = {st_reg.buf0[14:0], 1'b0};
              st_next.obits = data_bits(st_reg.org_word) - 5'h01;
            end
          end
        end
        seac_pkg::ST_SWEEP: begin
          mem_if.wr_en  = 1'b1;
          mem_if.addr   = st_reg.sweep;
          mem_if.wr_be  = 2'h3;
          st_next.sweep = st_reg.sweep + 8'h01;
          if (st_reg.sweep == `SEAC_LAST_WORD) begin
            st_next.state = seac_pkg::ST_BUSY;
            st_next.timer = `SEAC_TIMER_W'(PROG_CYCLES - 1);
          end
        end
        seac_pkg::ST_BUSY: begin
          // serial clock and data in are not looked at here
          if (st_reg.timer == `SEAC_TIMER_W'(0)) begin // RULE5 RULE15
            st_next.state = seac_pkg::ST_IDLE;
          end else begin
            st_next.timer = st_reg.timer - `SEAC_TIMER_W'(1);
          end
        end
      endcase
    end

    if (pop) begin
      st_next.buf0 = st_reg.buf1;
      st_next.bcnt = st_reg.bcnt - 2'h1;
    end
    push = st_reg.pend && SEL_IN && st_reg.state == seac_pkg::ST_READ;
    if (push) begin
      if (st_next.bcnt == 2'h0) begin
        st_next.buf0 = push_word;
      end else begin
        st_next.buf1 = push_word;
      end
      st_next.bcnt = st_next.bcnt + 2'h1;
    end

    if (!SEL_IN) begin
      st_next.oe = 1'b0; // RULE16
    end else if (st_next.state == seac_pkg::ST_READ) begin
      st_next.oe = 1'b1;
    end else if (st_next.status) begin
      st_next.oe  = 1'b1; // RULE8
      st_next.sdo = !(st_next.state inside {seac_pkg::ST_SWEEP, seac_pkg::ST_BUSY});
    end else begin
      st_next.oe = 1'b0;
    end
  end

  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      st_reg <= seac_pkg::SEAC_REGS_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign SDO_OUT    = st_reg.sdo;
  assign SDO_OE_OUT = st_reg.oe;

  default clocking cb @(posedge REF_CLK_IN);
  endclocking
  default disable iff (!RESET_N_IN);

  property p_cs_low_release;
    !SEL_IN |=> !SDO_OE_OUT && st_reg.state != seac_pkg::ST_CMD
      && st_reg.state != seac_pkg::ST_READ;
  endproperty
  a_cs_low_release: assert property (p_cs_low_release) // RULE16
    else $error("select low did not release data out");

  property p_zero_skip;
    st_reg.state == seac_pkg::ST_IDLE && SEL_IN && sclk_rise && !SDI_IN
      |=> st_reg.state == seac_pkg::ST_IDLE;
  endproperty
  a_zero_skip: assert property (p_zero_skip) // RULE11
    else $error("leading zero started an instruction");

  property p_org_latch;
    st_reg.state == seac_pkg::ST_IDLE && SEL_IN && sclk_rise && SDI_IN
      |=> st_reg.state == seac_pkg::ST_CMD && st_reg.org_word == $past(WIDTH_SEL_IN);
  endproperty
  a_org_latch: assert property (p_org_latch) // RULE13
    else $error("organisation not taken at start bit");

  property p_read_start;
    $rose(st_reg.state == seac_pkg::ST_READ)
      |-> st_reg.ptr == st_reg.addr && SDO_OE_OUT && !SDO_OUT;
  endproperty
  a_read_start: assert property (p_read_start) // RULE2
    else $error("read did not load pointer or send the zero bit");

  property p_stream_next;
    st_reg.state == seac_pkg::ST_READ && SEL_IN && sclk_rise && st_reg.obits == 5'h00
      && st_reg.bcnt != 2'h0
      |=> st_reg.obits == data_bits(st_reg.org_word) - 5'h01
      && st_reg.state == seac_pkg::ST_READ;
  endproperty
  a_stream_next: assert property (p_stream_next) // RULE3
    else $error("stream did not continue with next location");

  property p_ptr_wrap;
    mem_if.rd_en && st_reg.org_word && st_reg.ptr[7:0] == 8'hFF |=> st_reg.ptr == 9'h000;
  endproperty
  a_ptr_wrap: assert property (p_ptr_wrap) // RULE4
    else $error("pointer did not wrap to zero");

  property p_timer_runs;
    st_reg.state == seac_pkg::ST_BUSY && st_reg.timer != `SEAC_TIMER_W'(0)
      |=> st_reg.state == seac_pkg::ST_BUSY && st_reg.timer == $past(st_reg.timer) - 1'b1;
  endproperty
  a_timer_runs: assert property (p_timer_runs) // RULE5
    else $error("program timer stalled");

  property p_write_now;
    !SEL_IN && st_reg.state == seac_pkg::ST_DONE && st_reg.prog && st_reg.wen && !st_reg.all
      |-> mem_if.wr_en ##1 st_reg.state == seac_pkg::ST_BUSY;
  endproperty
  a_write_now: assert property (p_write_now) // RULE6
    else $error("single write did not program directly");

  property p_one_location;
    mem_if.wr_en && st_reg.state != seac_pkg::ST_SWEEP
      |-> $countones(mem_if.wr_be) == (st_reg.org_word ? 2 : 1) ##1 !mem_if.wr_en;
  endproperty
  a_one_location: assert property (p_one_location) // RULE7
    else $error("single write touched more than one location");

  property p_busy_shown;
    SEL_IN && st_reg.state == seac_pkg::ST_BUSY && st_reg.timer != `SEAC_TIMER_W'(0)
      |=> SDO_OE_OUT && !SDO_OUT;
  endproperty
  a_busy_shown: assert property (p_busy_shown) // RULE8
    else $error("busy not shown while programming");

  property p_ready_shown;
    SEL_IN && st_reg.state == seac_pkg::ST_BUSY && st_reg.timer == `SEAC_TIMER_W'(0)
      |=> SDO_OE_OUT && SDO_OUT;
  endproperty
  a_ready_shown: assert property (p_ready_shown) // RULE8
    else $error("ready not shown after programming");

  property p_busy_deaf;
    st_reg.state == seac_pkg::ST_BUSY |=> st_reg.state != seac_pkg::ST_CMD;
  endproperty
  a_busy_deaf: assert property (p_busy_deaf) // RULE15
    else $error("instruction decoded while busy");
endmodule
`default_nettype wire

// ---- testbench/seac_host.sv ----
`default_nettype none
module seac_host #(
  parameter int HALF = 100
) (
  input  wire logic clk_in,
  input  wire logic sdo_in,
  input  wire logic oe_in,
  output var logic  sel_out,
  output var logic  sclk_out,
  output var logic  sdi_out
);
  timeunit 1ns;
  timeprecision 100ps;

  // a released data out reads as the inverse of its last level, so no stale bit passes
  logic line_q;
  assign line_q = oe_in ? sdo_in : !sdo_in;

  initial begin
    sel_out = 1'b0;
    sclk_out = 1'b0;
    sdi_out = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  // 2*HALF cycles is 1 us; data out stands from one rise to the next
  task automatic bit_io(input logic b, output logic q);
    sdi_out <= b;
    wait_clk(HALF);
    sclk_out <= 1'b1;
    wait_clk(HALF);
    q = line_q;
    sclk_out <= 1'b0;
  endtask

  task automatic send(input logic [31:0] v, input int n);
    logic q;
    for (int i = n - 1; i >= 0; i--) begin
      bit_io(v[i], q);
    end
  endtask

  task automatic recv(input int n, output logic [15:0] v);
    logic q;
    v = '0;
    for (int i = 0; i < n; i++) begin
      bit_io(1'b0, q);
      v = {v[14:0], q};
    end
  endtask

  task automatic select();
    sel_out <= 1'b1;
    wait_clk(20);
  endtask

  task automatic instr(input logic [1:0] op, input logic [8:0] a, input int ab);
    logic [31:0] v;
    v = (32'h4 | 32'(op)) << ab | 32'(a);
    select();
    send(32'h0, 2);
    send(v, ab + 3);
  endtask

  // invert data in so a stale level is never mistaken for a held one
  task automatic close();
    sel_out <= 1'b0;
    sdi_out <= ~sdi_out;
    wait_clk(60);
  endtask

  task automatic poll(input int tg, output logic [3:0] st, output logic rdy);
    logic q;
    select();
    st[3:2] = {oe_in, sdo_in};
    for (int i = 0; i < tg; i++) begin
      bit_io(1'b1, q);
    end
    st[1:0] = {oe_in, sdo_in};
    rdy = 1'b0;
    for (int i = 0; i < 2000 && !rdy; i++) begin
      wait_clk(1);
      rdy = oe_in && line_q;
    end
  endtask
endmodule
`default_nettype wire

// ---- testbench/seac_core_test.sv ----
`default_nettype none
module seac_core_test;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk = 1'b0;
  logic rst_n;
  logic width_sel;
  logic sel;
  logic sclk;
  logic sdi;
  logic sdo;
  logic oe;
  int   fails = 0;
  int   compares = 0;

  always #2.5 clk = ~clk;

  seac_core #(.PROG_CYCLES(1000)) dut_u (
    .REF_CLK_IN   (clk),
    .RESET_N_IN   (rst_n),
    .SEL_IN       (sel),
    .SCLK_IN      (sclk),
    .SDI_IN       (sdi),
    .WIDTH_SEL_IN (width_sel),
    .SDO_OUT      (sdo),
    .SDO_OE_OUT   (oe)
  );

  seac_host host_u (
    .clk_in   (clk),
    .sdo_in   (sdo),
    .oe_in    (oe),
    .sel_out  (sel),
    .sclk_out (sclk),
    .sdi_out  (sdi)
  );

  task automatic finish_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // busy must show at select and survive clocks on data in
  task automatic prog(input int tg);
    logic [3:0] st;
    logic       rdy;
    host_u.close();
    host_u.poll(tg, st, rdy);
    chk({12'h0, st}, 16'h000A);
    chk({15'h0, rdy}, 16'h0001);
    if (!rdy) begin
      finish_test();
    end else begin
      host_u.close();
    end
  endtask

  task automatic wr(input logic [1:0] op, input logic [8:0] a, input logic [15:0] d,
                    input int ab, input int db, input int tg);
    host_u.instr(op, a, ab);
    host_u.send({16'h0, d}, db);
    prog(tg);
  endtask

  task automatic grp(input logic [8:0] a);
    host_u.instr(2'h0, a, 8);
    host_u.close();
  endtask

  task automatic rd(input logic [8:0] a, input int ab, input int db,
                    input logic [15:0] e0, input logic [15:0] e1);
    logic [15:0] v;
    host_u.instr(2'h2, a, ab);
    chk({14'h0, oe, sdo}, 16'h0002);
    host_u.recv(db, v);
    chk(v, e0);
    host_u.recv(db, v);
    chk(v, e1);
    host_u.close();
    chk({15'h0, oe}, 16'h0000);
  endtask

  task automatic t_program();
    grp(9'h0C0);
    wr(2'h1, 9'h005, 16'hA5C3, 8, 16, 3);
    wr(2'h1, 9'h006, 16'h3C5A, 8, 16, 0);
    wr(2'h1, 9'h005, 16'h5AA5, 8, 16, 0);
    wr(2'h1, 9'h0FF, 16'h1234, 8, 16, 0);
    wr(2'h3, 9'h000, 16'h0000, 8, 0, 0);
    $display("program test done");
  endtask

  // byte 11 is the low half of word 5, byte 10 its high half
  task automatic t_bytes();
    width_sel <= 1'b0;
    wr(2'h1, 9'h00B, 16'h007E, 9, 8, 0);
    rd(9'h00A, 9, 8, 16'h005A, 16'h007E);
    width_sel <= 1'b1;
    $display("byte test done");
  endtask

  task automatic t_refuse();
    host_u.select();
    host_u.send(32'h7, 3);
    host_u.close();
    grp(9'h000);
    host_u.instr(2'h1, 9'h006, 8);
    host_u.send(32'h0, 16);
    host_u.close();
    host_u.select();
    chk({15'h0, oe}, 16'h0000);
    host_u.close();
    $display("refuse test done");
  endtask

  // word 6 still holds its value: the partial erase and locked write did nothing
  task automatic t_stream();
    rd(9'h005, 8, 16, 16'h5A7E, 16'h3C5A);
    rd(9'h0FF, 8, 16, 16'h1234, 16'hFFFF);
    $display("stream test done");
  endtask

  // fill every word, then clear it all; read back by bytes, across the top wrap
  task automatic t_all();
    grp(9'h0C0);
    wr(2'h0, 9'h040, 16'hC35A, 8, 16, 0);
    width_sel <= 1'b0;
    rd(9'h1FF, 9, 8, 16'h005A, 16'h00C3);
    width_sel <= 1'b1;
    wr(2'h0, 9'h080, 16'h0000, 8, 0, 0);
    width_sel <= 1'b0;
    rd(9'h009, 9, 8, 16'h00FF, 16'h00FF);
    width_sel <= 1'b1;
    $display("all test done");
  endtask

  initial begin
    rst_n = 1'b0;
    width_sel = 1'b1;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_program();
    t_bytes();
    t_refuse();
    t_stream();
    t_all();
    finish_test();
  end
endmodule
`default_nettype wire
